/* File: logic/ivdm_pkg.sv */
// constants, types and source map for the interrupt vector and dma trigger map
package ivdm_pkg;

	// source population and table geometry
	localparam int NUM_IRQ = 160;
	localparam int IRQ_WORDS = 10;
	localparam int PRI_WORDS = 40;
	localparam int PRI_FIELDS = 4;
	localparam int PRI_FIELD_STRIDE = 4;
	localparam int PRI_W = 3;
	localparam int REG_W = 16;
	localparam logic [7:0] VECTOR_BIAS = 8'h08;
	localparam logic [23:0] TABLE_ADDR_BIAS = 24'h000014;

	// avalon byte offsets of each register group
	localparam int BUS_AW = 12;
	localparam logic [11:0] FLAG_BASE = 12'h000;
	localparam logic [11:0] ENABLE_BASE = 12'h040;
	localparam logic [11:0] PRIO_BASE = 12'h080;
	localparam logic [11:0] DMA_BASE = 12'h200;
	localparam int MAX_CH = 16;

	// field layout and reset values
	localparam int FORCE_BIT = 15;
	localparam int SEL_W = 8;
	localparam logic [15:0] PRIO_FIELD_MASK = 16'h7777;
	localparam logic [15:0] PRIO_RESET = 16'h0000;
	localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_FETCH = 2'b01,
		BUS_ACK = 2'b10
	} ivdm_bus_e;

	// which request numbers own flag, enable and priority bits
	function automatic logic ivdm_irq_present(input int n, input logic has_can, input logic full_pkg);
		logic p;
		p = 1'b0;
		if (n <= 40) p = 1'b1;
		if (n >= 41 && n <= 44) p = 1'b1;
		if (n == 45) p = full_pkg;
		if (n == 47 || n == 48 || n == 51 || n == 52) p = 1'b1;
		if (n == 49 || n == 50) p = 1'b1;
		if (n == 53 || n == 54) p = 1'b1;
		if (n == 55 || n == 56) p = has_can;
		if (n == 57 || n == 73) p = 1'b1;
		if (n == 58 || n == 75) p = 1'b1;
		if (n == 59 || n == 60) p = 1'b1;
		if (n == 62) p = full_pkg;
		if (n == 65 || n == 66) p = 1'b1;
		if (n == 67 || n == 77) p = 1'b1;
		if (n == 70 || n == 71) p = has_can;
		if (n >= 81 && n <= 83) p = 1'b1;
		if (n >= 87 && n <= 89) p = 1'b1;
		if (n == 90 || n == 91) p = 1'b1;
		if (n >= 94 && n <= 99) p = 1'b1;
		if (n >= 145 && n <= 150) p = 1'b1;
		return p;
	endfunction

	function automatic logic [NUM_IRQ-1:0] ivdm_present_mask(input logic has_can, input logic full_pkg);
		logic [NUM_IRQ-1:0] m;
		m = '0;
		for (int i = 0; i < NUM_IRQ; i++) begin
			m[i] = ivdm_irq_present(i, has_can, full_pkg);
		end
		return m;
	endfunction

endpackage

/* File: logic/ivdm_prio_if.sv */
// carrier between the controller and its priority word memory
`timescale 1ns/100ps
interface ivdm_prio_if #(
	parameter int AW = 6,
	parameter int DW = 16
);
	logic ce;
	logic we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr_a;
	logic [AW-1:0] raddr_b;
	logic [DW-1:0] rdata_a;
	logic [DW-1:0] rdata_b;

	modport ctrl (output ce, we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
	modport mem (input ce, we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
endinterface

/* File: logic/ivdm_prio_mem.sv */
// priority word memory: one write port, two registered read ports
`timescale 1ns/100ps
module ivdm_prio_mem #(
	parameter int DEPTH = 40
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	ivdm_prio_if.mem pm
);

	typedef struct packed {
		logic [DEPTH-1:0][15:0] word;
		logic [15:0] rd_a;
		logic [15:0] rd_b;
	} ivdm_mem_s;

	ivdm_mem_s s_q;
	ivdm_mem_s s_d;

	assign pm.rdata_a = s_q.rd_a;
	assign pm.rdata_b = s_q.rd_b;

	// read ports see the old word on a same-cycle write
	always_comb begin
		s_d = s_q;
		s_d.rd_a = s_q.word[pm.raddr_a];
		s_d.rd_b = s_q.word[pm.raddr_b];
		if (pm.we) begin
			s_d.word[pm.waddr] = pm.wdata;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q.word <= {DEPTH{ivdm_pkg::PRIO_RESET}};
			s_q.rd_a <= 16'h0000;
			s_q.rd_b <= 16'h0000;
		end else if (pm.ce) begin
			s_q <= s_d;
		end
	end

endmodule

/* File: logic/ivdm_top.sv */
// interrupt source map, priority resolver and dma trigger select
//
// Summary of operation
// - output compare 5-8: vectors 49-52, requests 41-44, word 2 bits 9-12
// - parallel master port: vector 53, request 45, word 2 bit 13, full package only
// - second i2c slave/master: vectors 57-58, requests 49-50, word 3 bits 1-2
// - external pin irq three/four: vectors 61-62, requests 53-54, word 3 bits 5-6
// - second can rx-ready and event: vectors 63-64, requests 55-56, can variants only
// - pwm special events: vector 65/request 57 and vector 81/request 73
// - position counter compares: vectors 66 and 83, requests 58 and 75
// - codec serial fault and done: vectors 67-68, requests 59-60, word 3 bits 11-12
// - real time calendar: vector 70, request 62, word 3 bit 14, full package only
// - uart 1/2 errors: vectors 73-74, requests 65-66, word 4 bits 1-2
// - crc generator: vector 75, request 67, word 4 bit 3
// - can 1/2 tx request: vectors 78-79, requests 70-71, word 4 bits 6-7, can variants only
// - uart 3 error/rx/tx: vectors 89-91, requests 81-83, word 5 bits 1-3
// - uart 4 error/rx/tx: vectors 95-97, requests 87-89, word 5 bits 7-9
// - third spi error/done: vectors 98-99, requests 90-91, word 5 bits 10-11
// - pwm generators 1-6: vectors 102-107, requests 94-99
// - trigger sequencer step, watchdog, irq 0-3: vectors 153-158, requests 145-150
// - equal priority resolves by natural order: lower vector number wins
// - manual trigger bit forces one transfer; otherwise selected request starts transfers
// - software cannot clear manual trigger; done or channel disable clears it
// - eight-bit select field picks the request number that triggers the channel
// - trigger select bits 14 to 8 read as zero
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/100ps
module ivdm_top #(
	parameter int NUM_CH = 4,
	parameter logic HAS_CAN = 1'b1,
	parameter logic FULL_PACKAGE = 1'b1
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [11:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [ivdm_pkg::NUM_IRQ-1:0] src_event_i,
	input wire logic [NUM_CH-1:0] chan_enable_i,
	input wire logic [NUM_CH-1:0] dma_done_i,
	output logic irq_req_o,
	output logic [7:0] irq_vector_o,
	output logic [7:0] irq_number_o,
	output logic [2:0] irq_level_o,
	output logic [23:0] irq_table_addr_o,
	output logic [NUM_CH-1:0] dma_start_o
);

	localparam int NI = ivdm_pkg::NUM_IRQ;
	localparam logic [NI-1:0] PRESENT = ivdm_pkg::ivdm_present_mask(HAS_CAN, FULL_PACKAGE);
	localparam logic [9:0] FLAG_W0 = ivdm_pkg::FLAG_BASE[11:2];
	localparam logic [9:0] ENABLE_W0 = ivdm_pkg::ENABLE_BASE[11:2];
	localparam logic [9:0] PRIO_W0 = ivdm_pkg::PRIO_BASE[11:2];
	localparam logic [9:0] DMA_W0 = ivdm_pkg::DMA_BASE[11:2];
	localparam logic [5:0] LAST_PRI_WORD = 6'(ivdm_pkg::PRI_WORDS - 1);

	typedef struct packed {
		logic [NI-1:0] flag;
		logic [NI-1:0] en;
		ivdm_pkg::ivdm_bus_e bus;
		logic waitreq;
		logic [31:0] rdata;
		logic [5:0] scan_w;
		logic [5:0] eval_w;
		logic eval_vld;
		logic [2:0] best_pri;
		logic [7:0] best_irq;
		logic req;
		logic [7:0] vec;
		logic [7:0] num;
		logic [2:0] lvl;
		logic [23:0] taddr;
		logic [NUM_CH-1:0] force_b;
		logic [NUM_CH-1:0] fired;
		logic [NUM_CH-1:0] start;
		logic [NUM_CH-1:0][7:0] sel;
	} ivdm_state_s;

	ivdm_state_s s_q;
	ivdm_state_s s_d;

	ivdm_prio_if #(.AW(6), .DW(16)) pif ();

	ivdm_prio_mem #(
		.DEPTH(ivdm_pkg::PRI_WORDS)
	) u_prio_mem (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.pm(pif.mem)
	);

	// byte lanes 0 and 1 carry the sixteen implemented register bits
	function automatic logic [15:0] lane_mask(input logic [3:0] be);
		return {{8{be[1]}}, {8{be[0]}}};
	endfunction

	// word index of an address inside a group; the hit flag is decoded by the caller
	function automatic logic [9:0] group_index(input logic [9:0] wa, input logic [9:0] base);
		return wa - base;
	endfunction

	logic [9:0] word_addr;
	logic [9:0] flag_idx;
	logic [9:0] en_idx;
	logic [9:0] prio_idx;
	logic [9:0] dma_idx;
	logic hit_flag;
	logic hit_en;
	logic hit_prio;
	logic hit_dma;

	// address decode, shared by the read and the write path
	always_comb begin
		word_addr = avs_address_i[11:2];
		flag_idx = group_index(word_addr, FLAG_W0);
		en_idx = group_index(word_addr, ENABLE_W0);
		prio_idx = group_index(word_addr, PRIO_W0);
		dma_idx = group_index(word_addr, DMA_W0);
		hit_flag = word_addr >= FLAG_W0 && flag_idx < 10'(ivdm_pkg::IRQ_WORDS);
		hit_en = word_addr >= ENABLE_W0 && en_idx < 10'(ivdm_pkg::IRQ_WORDS);
		hit_prio = word_addr >= PRIO_W0 && prio_idx < 10'(ivdm_pkg::PRI_WORDS);
		hit_dma = word_addr >= DMA_W0 && dma_idx < 10'(NUM_CH);
	end

	// priority memory ports: bus on port a, resolver scan on port b
	assign pif.ce = ce_i;
	assign pif.raddr_a = hit_prio ? prio_idx[5:0] : 6'h00;
	assign pif.raddr_b = s_q.scan_w;
	assign pif.waddr = prio_idx[5:0];

	logic [15:0] pri_merge;
	logic [15:0] pri_keep;

	// reserved sources keep a zero priority field whatever is written
	always_comb begin
		pri_keep = 16'h0000;
		for (int k = 0; k < ivdm_pkg::PRI_FIELDS; k++) begin
			if (PRESENT[int'(prio_idx[5:0]) * ivdm_pkg::PRI_FIELDS + k]) begin
				pri_keep[k * ivdm_pkg::PRI_FIELD_STRIDE +: ivdm_pkg::PRI_W] = 3'h7;
			end
		end
		pri_merge = (pif.rdata_a & ~lane_mask(avs_byteenable_i))
			| (avs_writedata_i[15:0] & lane_mask(avs_byteenable_i));
		pri_merge = pri_merge & ivdm_pkg::PRIO_FIELD_MASK & pri_keep;
	end

	assign pif.we = s_q.bus == ivdm_pkg::BUS_ACK && avs_write_i && hit_prio;
	assign pif.wdata = pri_merge;

	// next state of everything the block holds
	always_comb begin
		logic [15:0] m;
		logic [15:0] old;
		logic [2:0] bp;
		logic [7:0] bi;
		logic [2:0] p;
		int idx;
		int ch;
		m = lane_mask(avs_byteenable_i);
		old = 16'h0000;
		bp = s_q.best_pri;
		bi = s_q.best_irq;
		p = 3'h0;
		idx = 0;
		ch = int'(dma_idx[3:0]);
		s_d = s_q;
		s_d.start = '0;

		// avalon slave: fetch cycle, then one cycle of waitrequest low
		unique case (s_q.bus)
			ivdm_pkg::BUS_IDLE: begin
				s_d.waitreq = 1'b1;
				if (avs_read_i || avs_write_i) begin
					s_d.bus = ivdm_pkg::BUS_FETCH;
				end
			end
			ivdm_pkg::BUS_FETCH: begin
				s_d.rdata = ivdm_pkg::UNMAPPED_READ;
				if (hit_flag) begin
					s_d.rdata = {16'h0000, s_q.flag[int'(flag_idx[3:0]) * 16 +: 16]};
				end else if (hit_en) begin
					s_d.rdata = {16'h0000, s_q.en[int'(en_idx[3:0]) * 16 +: 16]};
				end else if (hit_prio) begin
					s_d.rdata = {16'h0000, pif.rdata_a};
				end else if (hit_dma) begin
					s_d.rdata = {16'h0000, s_q.force_b[ch], 7'h00, s_q.sel[ch]};
				end
				s_d.waitreq = 1'b0;
				s_d.bus = ivdm_pkg::BUS_ACK;
			end
			ivdm_pkg::BUS_ACK: begin
				s_d.waitreq = 1'b1;
				s_d.bus = ivdm_pkg::BUS_IDLE;
				if (avs_write_i && hit_flag) begin
					old = s_q.flag[int'(flag_idx[3:0]) * 16 +: 16];
					s_d.flag[int'(flag_idx[3:0]) * 16 +: 16] = (old & ~m) | (avs_writedata_i[15:0] & m);
				end
				if (avs_write_i && hit_en) begin
					old = s_q.en[int'(en_idx[3:0]) * 16 +: 16];
					s_d.en[int'(en_idx[3:0]) * 16 +: 16] = (old & ~m) | (avs_writedata_i[15:0] & m);
				end
			end
			default: begin
				s_d.waitreq = 1'b1;
				s_d.bus = ivdm_pkg::BUS_IDLE;
			end
		endcase

		// reserved positions never hold a bit; a source event beats a same-cycle clear
		s_d.flag = (s_d.flag | src_event_i) & PRESENT;
		s_d.en = s_d.en & PRESENT;

		// resolver: one priority word (four sources) per cycle, full sweep in forty
		s_d.scan_w = s_q.scan_w == LAST_PRI_WORD ? 6'h00 : s_q.scan_w + 6'h01;
		s_d.eval_w = s_q.scan_w;
		s_d.eval_vld = 1'b1;
		if (s_q.eval_vld) begin
			for (int k = 0; k < ivdm_pkg::PRI_FIELDS; k++) begin
				idx = int'(s_q.eval_w) * ivdm_pkg::PRI_FIELDS + k;
				p = pif.rdata_b[k * ivdm_pkg::PRI_FIELD_STRIDE +: ivdm_pkg::PRI_W];
				// strictly greater only, so the lower number keeps a tie
				if (s_q.flag[idx] && s_q.en[idx] && p != 3'h0 && p > bp) begin
					bp = p;
					bi = 8'(idx);
				end
			end
			if (s_q.eval_w == LAST_PRI_WORD) begin
				s_d.req = bp != 3'h0;
				s_d.lvl = bp;
				s_d.num = bi;
				s_d.vec = bi + ivdm_pkg::VECTOR_BIAS;
				s_d.taddr = {15'h0000, bi, 1'b0} + ivdm_pkg::TABLE_ADDR_BIAS;
				bp = 3'h0;
				bi = 8'h00;
			end
		end
		s_d.best_pri = bp;
		s_d.best_irq = bi;

		// dma trigger: forced single transfer or the selected request number
		for (int c = 0; c < NUM_CH; c++) begin
			if (!chan_enable_i[c]) begin
				s_d.force_b[c] = 1'b0;
				s_d.fired[c] = 1'b0;
			end else if (s_q.force_b[c]) begin
				if (!s_q.fired[c]) begin
					s_d.start[c] = 1'b1;
					s_d.fired[c] = 1'b1;
				end else if (dma_done_i[c]) begin
					s_d.force_b[c] = 1'b0;
					s_d.fired[c] = 1'b0;
				end
			end else if (int'(s_q.sel[c]) < NI && src_event_i[s_q.sel[c]]) begin
				s_d.start[c] = 1'b1;
			end
		end

		// software may set the manual bit but a written zero is ignored
		if (s_q.bus == ivdm_pkg::BUS_ACK && avs_write_i && hit_dma) begin
			if (avs_byteenable_i[0]) begin
				s_d.sel[ch] = avs_writedata_i[ivdm_pkg::SEL_W-1:0];
			end
			if (avs_byteenable_i[1] && avs_writedata_i[ivdm_pkg::FORCE_BIT]) begin
				s_d.force_b[ch] = 1'b1;
			end
		end
	end

	// whole state in one register, frozen while the clock enable is low
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q.flag <= '0;
			s_q.en <= '0;
			s_q.bus <= ivdm_pkg::BUS_IDLE;
			s_q.waitreq <= 1'b1;
			s_q.rdata <= 32'h00000000;
			s_q.scan_w <= 6'h00;
			s_q.eval_w <= 6'h00;
			s_q.eval_vld <= 1'b0;
			s_q.best_pri <= 3'h0;
			s_q.best_irq <= 8'h00;
			s_q.req <= 1'b0;
			s_q.vec <= 8'h00;
			s_q.num <= 8'h00;
			s_q.lvl <= 3'h0;
			s_q.taddr <= 24'h000000;
			s_q.force_b <= '0;
			s_q.fired <= '0;
			s_q.start <= '0;
			s_q.sel <= '0;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	// every output straight from the state register
	assign avs_readdata_o = s_q.rdata;
	assign avs_waitrequest_o = s_q.waitreq;
	assign irq_req_o = s_q.req;
	assign irq_vector_o = s_q.vec;
	assign irq_number_o = s_q.num;
	assign irq_level_o = s_q.lvl;
	assign irq_table_addr_o = s_q.taddr;
	assign dma_start_o = s_q.start;

endmodule

/* File: testbench/ivdm_checker.sv */
// port level assertions for the interrupt map block
`timescale 1ns/100ps
module ivdm_checker #(
	parameter int NUM_CH = 4
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [11:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic [ivdm_pkg::NUM_IRQ-1:0] src_event_i,
	input wire logic [NUM_CH-1:0] chan_enable_i,
	input wire logic [NUM_CH-1:0] dma_done_i,
	input wire logic irq_req_o,
	input wire logic [7:0] irq_vector_o,
	input wire logic [7:0] irq_number_o,
	input wire logic [2:0] irq_level_o,
	input wire logic [23:0] irq_table_addr_o,
	input wire logic [NUM_CH-1:0] dma_start_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	logic absent;
	// request numbers that own no flag, enable or priority bits
	assign absent = irq_number_o inside {8'h2E, 8'h3D, 8'h3F, 8'h40, 8'h44, 8'h45, 8'h48, 8'h4A, 8'h4C,
		[8'h4E:8'h50], [8'h54:8'h56], 8'h5C, 8'h5D, [8'h64:8'h90]} || irq_number_o > 8'h96;
	a_vector_bias:
		assert property (irq_req_o |-> irq_vector_o == irq_number_o + 8'h08) else $error("vector off");
	a_table_addr:
		assert property (irq_req_o |-> irq_table_addr_o == {15'h0000, irq_number_o, 1'b0} + 24'h000014)
		else $error("table address off");
	a_reserved_never:
		assert property (irq_req_o |-> !absent) else $error("reserved number won");
	a_level_ties_req:
		assert property (irq_req_o == (irq_level_o != 3'h0)) else $error("level and request disagree");
	a_winner_holds:
		assert property ($changed(irq_number_o) |=> $stable(irq_number_o) [*8]) else $error("winner churns");
	a_ack_latency:
		assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o [*2] ##1 !avs_waitrequest_o)
		else $error("ack not in third cycle");
	a_ack_single:
		assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("ack longer than one cycle");
	a_select_zeros:
		assert property (avs_read_i && !avs_waitrequest_o && avs_address_i[11:6] == 6'h08
			|-> avs_readdata_o[31:16] == 16'h0000 && avs_readdata_o[14:8] == 7'h00)
		else $error("select register high bits set");
	a_start_enabled:
		assert property (dma_start_o != '0 |-> (dma_start_o & ~$past(chan_enable_i)) == '0)
		else $error("start on disabled channel");
	a_forced_once:
		assert property (dma_start_o[0] |=> !dma_start_o[0]) else $error("start longer than a pulse");
	// main scenarios reached
	c_irq: cover property ($rose(irq_req_o));
	c_auto: cover property (dma_start_o[1]);
	c_write: cover property (avs_write_i && !avs_waitrequest_o);
endmodule

/* File: testbench/ivdm_dma_model.sv */
// dma channels on the far side: report done a set lag after each start
`timescale 1ns/100ps
module ivdm_dma_model #(
	parameter int NUM_CH = 4
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [NUM_CH-1:0] start_i,
	input wire logic [7:0] lag_i,
	output logic [NUM_CH-1:0] done_o
);
	int cnt [NUM_CH];
	// lag 0 answers promptly; a long lag lets software poke the channel mid transfer
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= '{default: 0};
			done_o <= '0;
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				done_o[c] <= (cnt[c] == 1);
				if (start_i[c]) cnt[c] <= int'(lag_i) + 1;
				else if (cnt[c] > 0) cnt[c] <= cnt[c] - 1;
			end
		end
	end
endmodule

/* File: testbench/interrupt_vector_and_dma_trigger_map_tb_top.sv */
// bench for the interrupt map block: register bus, resolver and dma triggers
`timescale 1ns/100ps
module interrupt_vector_and_dma_trigger_map_tb_top;
	localparam int NUM_CH = 4;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic [159:0] ev = '0;
	logic [3:0] en = 4'h0;
	logic ce = 1'b1;
	logic [7:0] lag = 8'h14;
	logic [31:0] seed = 32'hE682;
	logic [31:0] rdata;
	logic [23:0] taddr;
	logic [3:0] done, start;
	logic [7:0] vec, num;
	logic [2:0] lvl;
	logic wreq, req;
	int n_mismatch = 0;
	int check_count = 0;
	logic [31:0] exp_q[$];
	string what_q[$];
	int srcs[31] = '{41, 44, 45,
		49, 50, 53, 54, 55, 56,
		57, 73, 58, 75, 59, 60, 62,
		65, 66, 67, 70, 71,
		81, 83, 87, 89, 90, 91, 94, 99, 145, 150};
	ivdm_top #(.NUM_CH(NUM_CH)) dut_u (.clock_i(clock), .rst_n_i(rst_n), .ce_i(ce), .avs_address_i(addr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .src_event_i(ev), .chan_enable_i(en),
		.dma_done_i(done), .irq_req_o(req), .irq_vector_o(vec), .irq_number_o(num), .irq_level_o(lvl),
		.irq_table_addr_o(taddr), .dma_start_o(start));
	ivdm_dma_model #(.NUM_CH(NUM_CH)) far_u (.clock_i(clock), .rst_n_i(rst_n), .start_i(start), .lag_i(lag),
		.done_o(done));
	// free running clock
	initial begin
		forever #4 clock = ~clock;
	end
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
	endtask
	// one access, held until waitrequest is sampled low; no fixed latency assumed
	task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		rd <= !w;
		wr <= w;
		do @(posedge clock); while (wreq !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rd_exp(logic [11:0] a, logic [31:0] e, string what);
		exp_q.push_back(e);
		what_q.push_back(what);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic pulse(int n);
		@(posedge clock);
		ev[n] <= 1'b1;
		@(posedge clock);
		ev <= '0;
	endtask
	// start pulse lasts one cycle, so every edge of the window is looked at
	task automatic start_win(int ch, logic e, string what);
		logic s;
		s = 1'b0;
		repeat (4) begin
			@(posedge clock);
			s = s | start[ch];
		end
		check(what, {31'h0, e}, {31'h0, s});
	endtask
	// two sweeps cover the worst latency and any half finished sweep
	task automatic irq_expect(int n, logic [2:0] l);
		repeat (100) @(posedge clock);
		check("irq_req", 32'h1, 32'(req));
		check("irq_number", n, 32'(num));
		check("irq_vector", n + 8, 32'(vec));
		check("irq_table", 2 * n + 32'h14, 32'(taddr));
		check("irq_level", 32'(l), 32'(lvl));
	endtask
	// compares each read answer with the oldest note
	always @(posedge clock) begin
		if (rd && wreq === 1'b0 && exp_q.size() > 0) check(what_q.pop_front(), exp_q.pop_front(), rdata);
	end
	// watchdog well beyond the expected run length
	initial begin
		repeat (40000) @(posedge clock);
		n_mismatch++;
		final_report();
	end
	// main sequence
	initial begin
		int n;
		logic [11:0] w;
		logic [11:0] p;
		logic [7:0] s;
		do_reset();
		rd_exp(12'h000, 32'h0, "flag reset");
		rd_exp(12'h080, 32'h0, "prio reset");
		bus(1'b1, 12'h3FC, 32'hFFFF);
		rd_exp(12'h3FC, 32'h0, "unmapped");
		$display("test reset done");
		bus(1'b1, 12'h200, 32'hFFFF);
		start_win(0, 1'b0, "start while off");
		rd_exp(12'h200, 32'h00FF, "select only");
		@(posedge clock);
		en <= 4'h3;
		bus(1'b1, 12'h200, 32'h8055);
		start_win(0, 1'b1, "forced start");
		rd_exp(12'h200, 32'h8055, "force held");
		bus(1'b1, 12'h200, 32'h0055);
		rd_exp(12'h200, 32'h8055, "force not clearable");
		repeat (30) @(posedge clock);
		rd_exp(12'h200, 32'h0055, "force cleared by done");
		bus(1'b1, 12'h200, 32'h8055);
		en <= 4'h2;
		rd_exp(12'h200, 32'h0055, "force cleared by disable");
		$display("test dma manual done");
		lag <= 8'h00;
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			s = (i == 0) ? 8'h00 : (i == 1) ? 8'h0A : (i == 2) ? 8'h5B : 8'(seed % 160);
			bus(1'b1, 12'h204, {24'h0, s});
			rd_exp(12'h204, {24'h0, s}, "select readback");
			pulse((s + 1) % 160);
			start_win(1, 1'b0, "other request");
			pulse(s);
			start_win(1, 1'b1, "auto start");
		end
		$display("test dma auto done");
		// the dma pulses left flags behind; clear every flag word before the map test
		for (int k = 0; k < 10; k++) begin
			bus(1'b1, 12'(4 * k), 32'h0);
		end
		// clock enable low: an event must not reach the flags
		ce <= 1'b0;
		pulse(47);
		@(posedge clock);
		ce <= 1'b1;
		rd_exp(12'h008, 32'h0, "frozen flag");
		foreach (srcs[i]) begin
			n = srcs[i];
			w = 12'(4 * (n / 16));
			p = 12'(12'h080 + 4 * (n / 4));
			pulse(n);
			rd_exp(w, 32'h1 << (n % 16), "flag bit");
			bus(1'b1, 12'h040 + w, 32'h1 << (n % 16));
			repeat (100) @(posedge clock);
			check("req at prio 0", 32'h0, 32'(req));
			bus(1'b1, p, 32'h1 << (4 * (n % 4)));
			irq_expect(n, 3'h1);
			bus(1'b1, w, 32'h0);
			bus(1'b1, 12'h040 + w, 32'h0);
			bus(1'b1, p, 32'h0);
		end
		pulse(46);
		rd_exp(12'h008, 32'h0, "reserved flag");
		bus(1'b1, 12'h048, 32'h4000);
		rd_exp(12'h048, 32'h0, "reserved enable");
		$display("test irq map done");
		bus(1'b1, 12'h0B0, 32'h30);
		bus(1'b1, 12'h0B4, 32'h30);
		bus(1'b1, 12'h04C, 32'h22);
		@(posedge clock);
		ev[49] <= 1'b1;
		ev[53] <= 1'b1;
		@(posedge clock);
		ev <= '0;
		irq_expect(49, 3'h3);
		bus(1'b1, 12'h0B4, 32'h50);
		irq_expect(53, 3'h5);
		$display("test irq tie done");
		do_reset();
		rd_exp(12'h204, 32'h0, "select after reset");
		$display("test second reset done");
		@(posedge clock);
		final_report();
	end
endmodule
bind ivdm_top ivdm_checker #(.NUM_CH(NUM_CH)) chk_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .src_event_i(src_event_i), .chan_enable_i(chan_enable_i),
	.dma_done_i(dma_done_i), .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o), .irq_number_o(irq_number_o),
	.irq_level_o(irq_level_o), .irq_table_addr_o(irq_table_addr_o), .dma_start_o(dma_start_o));
